/* ipc_chan_model.sv */
// far-side channel model: channel 0 transfer that stays busy for a set span
`timescale 1ns/10ps
module ipc_chan_model (
    input wire logic sys_clk,
    input wire logic start,
    input wire logic [7:0] span,
    output logic [7:0] xfer_busy,
    output logic [7:0] op_done
);
    logic [7:0] cnt_reg = 8'h00;
    always @(posedge sys_clk) begin
        if (start) begin
            cnt_reg <= span;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
    // busy while the transfer runs, done beat on its last cycle
    assign xfer_busy = {7'h00, cnt_reg != 8'h00};
    assign op_done = {7'h00, cnt_reg == 8'h01};
endmodule

/* ipc_defines.svh */
// constants for the interrupt and pause control block
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH

// ****************************************
// widths and timing
// ****************************************
`define IPC_CLK_HZ 40000000
`define IPC_PAUSE_LIMIT_MS 40
`define IPC_PAUSE_CYC ((`IPC_CLK_HZ / 1000) * `IPC_PAUSE_LIMIT_MS)

// ****************************************
// pause sensing mask bits
// ****************************************
`define IPC_PB_TYPE_BUSY 8
`define IPC_PB_TYPE_FIN 9
`define IPC_PB_TYPE_REP 10
`define IPC_PB_SM_BUSY 11

// ****************************************
// interrupt mask bits
// ****************************************
`define IPC_IB_RTC 8
`define IPC_IB_EXP_BCD 9
`define IPC_IB_OVF_DIV 10
`define IPC_IB_SM_DONE 11

// ****************************************
// internal status bits
// ****************************************
`define IPC_SB_PARITY 0
`define IPC_SB_BUSY_RD 1
`define IPC_SB_BUSY_WR 2
`define IPC_SB_EXT_REJ 3
`define IPC_SB_NORESP 4
`define IPC_SB_ILL_WR 5
`define IPC_SB_PRESET 6
`define IPC_SB_CH_INT 7
`define IPC_SB_EXP 8
`define IPC_SB_OVF 9
`define IPC_SB_DIV 10
`define IPC_SB_BCD 11

// ****************************************
// reset values
// ****************************************
`define IPC_MASK_RST 12'h000
`define IPC_FITTED_DEF 8'hFF

`endif

/* ipc_pkg.sv */
// types shared by the interrupt and pause control block
package ipc_pkg;
    typedef enum logic [3:0] {
        IPC_OP_NONE = 4'h0,
        IPC_OP_COPY_STATUS = 4'h1,
        IPC_OP_SENSE_STATUS = 4'h2,
        IPC_OP_PAUSE = 4'h3,
        IPC_OP_PRIO_PAUSE = 4'h4,
        IPC_OP_INT_ON = 4'h5,
        IPC_OP_INT_OFF = 4'h6,
        IPC_OP_CLEAR_FAULTS = 4'h7,
        IPC_OP_SET_MASK = 4'h8,
        IPC_OP_CLEAR_MASK = 4'h9,
        IPC_OP_LOCKOUT = 4'hA,
        IPC_OP_FLOAT_FAULT = 4'hB,
        IPC_OP_DEC_FAULT = 4'hC
    } ipc_op_t;

    typedef enum logic [1:0] {
        IPC_NEXT_P1 = 2'h0,
        IPC_NEXT_P2 = 2'h1,
        IPC_NEXT_INTR = 2'h2
    } ipc_next_t;

    typedef enum logic {
        IPC_ST_IDLE = 1'b0,
        IPC_ST_PAUSE = 1'b1
    } ipc_state_t;
endpackage

/* ipc_timer.sv */
// pause timeout counter
`timescale 1ns/10ps
module ipc_timer import ipc_pkg::*; #(
    parameter int CYCLES = 1600000
) (
    input wire logic sys_clk,
    input wire logic rst_sync_b,
    ipc_tmr_if.tmr tif
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg;

    // count restarts whenever the pause ends, so each pause gets the full window
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            count_reg <= '0;
        end else if (!tif.run || count_reg == LAST) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tif.expired <= 1'b0;
        end else begin
            tif.expired <= tif.run && count_reg == LAST;
        end
    end
endmodule

/* ipc_tmr_if.sv */
// link between the pause sequencer and its timeout counter
`timescale 1ns/10ps
interface ipc_tmr_if;
    logic run;
    logic expired;
    modport ctl (output run, input expired);
    modport tmr (input run, output expired);
endinterface

/* ipc_top.sv */
// interrupt system and pause instruction control
// ****************************************
// Functional notes
// - copy status: status low, mask high, P+1
// - pause holds P while masked line active
// - pause longer than 40 ms resumes P+1
// - no active sensed line: skip to P+2
// - enabled interrupt ends pause, saves pause address
// - bits 08-10 never wait, decide at once
// - present finish/repeat condition clears that flag
// - pause bits: channels, typewriter, search/move
// - channel busy: transfer, control, reply/reject
// - priority pause also stops real-time clock
// - after enable, next instruction runs first
// - long instruction: interrupt from second address read
// - disabled until enable; conditions remain sensible
// - clear selected faults, pulse peripheral clear
// - interrupt bits: channels, clock, faults, search/move
// - set mask bits; unfitted channels stay zero
// - clear mask bits where operand is one
// - lockout blocks external interrupts while busy
// - lockout ends on finish, clear, negate
// - sensing an internal fault clears it
// - forced float and decimal faults set flags
// - status: parity, busy, rejects, illegal, faults
// ****************************************
`timescale 1ns/10ps
`include "ipc_defines.svh"
module ipc_top import ipc_pkg::*; #(
    parameter int PAUSE_CYCLES = `IPC_PAUSE_CYC,
    parameter logic [7:0] CHAN_FITTED = `IPC_FITTED_DEF
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire ipc_op_t instr_op,
    input wire logic [11:0] instr_operand,
    input wire logic [2:0] instr_ch,
    input wire logic address_read_cycle,
    input wire logic next_instruction_fetch,
    input wire logic [7:0] chan_xfer_busy,
    input wire logic [7:0] chan_ext_ctrl,
    input wire logic [7:0] chan_reply_reject,
    input wire logic [7:0] chan_parity_err,
    input wire logic [7:0] chan_busy_read,
    input wire logic [7:0] chan_busy_write,
    input wire logic [7:0] chan_ext_reject,
    input wire logic [7:0] chan_noresp_reject,
    input wire logic [7:0] chan_preset,
    input wire logic [7:0] chan_int_event,
    input wire logic [7:0] ext_int,
    input wire logic [7:0] chan_op_done,
    input wire logic [7:0] chan_cleared,
    input wire logic [7:0] negate_lockout,
    input wire logic illegal_write,
    input wire logic type_busy,
    input wire logic type_finish,
    input wire logic type_repeat,
    input wire logic search_move_busy,
    input wire logic search_move_done,
    input wire logic rtc_tick,
    input wire logic exp_fault_event,
    input wire logic ovf_fault_event,
    input wire logic div_fault_event,
    input wire logic bcd_fault_event,
    output logic done,
    output ipc_next_t next_sel,
    output logic pc_hold,
    output logic acc_load,
    output logic [23:0] acc_data,
    output logic int_request,
    output logic int_enabled,
    output logic [11:0] int_mask,
    output logic [7:0] lockout,
    output logic rtc_inhibit,
    output logic type_finish_clr,
    output logic type_repeat_clr,
    output logic periph_int_clear
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_b, rst_sync_b;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // ****************************************
    // state and decoded conditions
    // ****************************************
    logic [11:0] interrupt_enable_mask_reg;
    logic [7:0] chan_int_reg;
    logic exp_flt_reg, ovf_flt_reg, div_flt_reg, bcd_flt_reg;
    logic rtc_pend_reg, sm_done_reg;
    logic allow_reg, defer_phase_reg, address_read_cycle_seen_reg, prio_reg;
    ipc_state_t state_reg;
    logic [11:0] pmask_reg;
    logic [7:0] chan_busy;
    logic [11:0] pause_lines, pending, status;
    logic [11:0] sense_hit;
    logic irq_now, pause_active, go;
    ipc_tmr_if tif ();

    assign go = instr_valid && state_reg == IPC_ST_IDLE;
    assign chan_busy = chan_xfer_busy | chan_ext_ctrl | chan_reply_reject;
    assign pause_lines = {search_move_busy, ~type_repeat, ~type_finish, type_busy,
                          chan_busy};
    assign pause_active = |(pause_lines & pmask_reg);
    // external lines are blocked only while the locked channel is busy
    assign pending = {sm_done_reg, ovf_flt_reg | div_flt_reg, exp_flt_reg | bcd_flt_reg,
                      rtc_pend_reg, chan_int_reg | (ext_int & ~(lockout & chan_busy))};
    assign status = {bcd_flt_reg, div_flt_reg, ovf_flt_reg, exp_flt_reg,
                     chan_int_reg[instr_ch], chan_preset[instr_ch], illegal_write,
                     chan_noresp_reject[instr_ch], chan_ext_reject[instr_ch],
                     chan_busy_write[instr_ch], chan_busy_read[instr_ch],
                     chan_parity_err[instr_ch]};
    assign sense_hit = status & instr_operand;
    assign irq_now = int_enabled && allow_reg && |(pending & interrupt_enable_mask_reg);
    assign int_mask = interrupt_enable_mask_reg;

    // ****************************************
    // interrupt mask
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            interrupt_enable_mask_reg <= `IPC_MASK_RST;
        end else if (go && instr_op == IPC_OP_SET_MASK) begin
            interrupt_enable_mask_reg <= interrupt_enable_mask_reg
                | (instr_operand & {4'hF, CHAN_FITTED});
        end else if (go && instr_op == IPC_OP_CLEAR_MASK) begin
            interrupt_enable_mask_reg <= interrupt_enable_mask_reg & ~instr_operand;
        end
    end

    // ****************************************
    // sticky interrupt and fault flags
    // ****************************************
    // new events win over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            chan_int_reg <= 8'h00;
            rtc_pend_reg <= 1'b0;
            sm_done_reg <= 1'b0;
        end else begin
            chan_int_reg <= chan_int_event | (chan_int_reg
                & ~((go && instr_op == IPC_OP_CLEAR_FAULTS) ? instr_operand[7:0] : 8'h00));
            rtc_pend_reg <= rtc_tick | (rtc_pend_reg
                & ~(go && instr_op == IPC_OP_CLEAR_FAULTS && instr_operand[`IPC_IB_RTC]));
            sm_done_reg <= search_move_done | (sm_done_reg
                & ~(go && instr_op == IPC_OP_CLEAR_FAULTS && instr_operand[`IPC_IB_SM_DONE]));
        end
    end

    logic clr_eb, clr_od, sns;
    assign clr_eb = go && instr_op == IPC_OP_CLEAR_FAULTS && instr_operand[`IPC_IB_EXP_BCD];
    assign clr_od = go && instr_op == IPC_OP_CLEAR_FAULTS && instr_operand[`IPC_IB_OVF_DIV];
    assign sns = go && instr_op == IPC_OP_SENSE_STATUS;

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            exp_flt_reg <= 1'b0;
            ovf_flt_reg <= 1'b0;
            div_flt_reg <= 1'b0;
            bcd_flt_reg <= 1'b0;
        end else begin
            exp_flt_reg <= exp_fault_event || (go && instr_op == IPC_OP_FLOAT_FAULT)
                || (exp_flt_reg && !clr_eb && !(sns && sense_hit[`IPC_SB_EXP]));
            bcd_flt_reg <= bcd_fault_event || (go && instr_op == IPC_OP_DEC_FAULT)
                || (bcd_flt_reg && !clr_eb && !(sns && sense_hit[`IPC_SB_BCD]));
            ovf_flt_reg <= ovf_fault_event
                || (ovf_flt_reg && !clr_od && !(sns && sense_hit[`IPC_SB_OVF]));
            div_flt_reg <= div_fault_event
                || (div_flt_reg && !clr_od && !(sns && sense_hit[`IPC_SB_DIV]));
        end
    end

    // ****************************************
    // channel lockout
    // ****************************************
    // release events beat a new lockout request for the same channel
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            lockout <= 8'h00;
        end else begin
            lockout <= (lockout | ((go && instr_op == IPC_OP_LOCKOUT) ? instr_operand[7:0] : 8'h00))
                & ~(chan_op_done | chan_cleared | negate_lockout);
        end
    end

    // ****************************************
    // enable, disable and deferral
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            int_enabled <= 1'b0;
        end else if (go && instr_op == IPC_OP_INT_ON) begin
            int_enabled <= 1'b1;
        end else if (go && instr_op == IPC_OP_INT_OFF) begin
            int_enabled <= 1'b0;
        end
    end

    // phase 0 waits for the fetch after enable, phase 1 watches that instruction
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            allow_reg <= 1'b0;
            defer_phase_reg <= 1'b0;
            address_read_cycle_seen_reg <= 1'b0;
        end else if (go && instr_op == IPC_OP_INT_ON) begin
            allow_reg <= 1'b0;
            defer_phase_reg <= 1'b0;
            address_read_cycle_seen_reg <= 1'b0;
        end else if (!allow_reg) begin
            if (!defer_phase_reg) begin
                defer_phase_reg <= next_instruction_fetch;
            end else if (next_instruction_fetch) begin
                allow_reg <= 1'b1;
            end else if (address_read_cycle) begin
                allow_reg <= address_read_cycle_seen_reg;
                address_read_cycle_seen_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            int_request <= 1'b0;
        end else begin
            int_request <= irq_now;
        end
    end

    // ****************************************
    // instruction sequencing
    // ****************************************
    assign tif.run = state_reg == IPC_ST_PAUSE;

    ipc_timer #(.CYCLES(PAUSE_CYCLES)) u_timer (
        .sys_clk(sys_clk),
        .rst_sync_b(rst_sync_b),
        .tif(tif)
    );

    logic is_pause, quick;
    assign is_pause = instr_op == IPC_OP_PAUSE || instr_op == IPC_OP_PRIO_PAUSE;
    assign quick = |instr_operand[`IPC_PB_TYPE_REP:`IPC_PB_TYPE_BUSY];

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_reg <= IPC_ST_IDLE;
            pmask_reg <= 12'h000;
            prio_reg <= 1'b0;
        end else begin
            case (state_reg)
                IPC_ST_IDLE: begin
                    if (go && is_pause && !quick
                        && |(pause_lines & instr_operand)) begin
                        state_reg <= IPC_ST_PAUSE;
                        pmask_reg <= instr_operand;
                        prio_reg <= instr_op == IPC_OP_PRIO_PAUSE;
                    end
                end
                IPC_ST_PAUSE: begin
                    if (irq_now || !pause_active || tif.expired) begin
                        state_reg <= IPC_ST_IDLE;
                        prio_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= IPC_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pc_hold <= 1'b0;
            rtc_inhibit <= 1'b0;
        end else begin
            pc_hold <= state_reg == IPC_ST_PAUSE
                ? !(irq_now || !pause_active || tif.expired)
                : go && is_pause && !quick && |(pause_lines & instr_operand);
            rtc_inhibit <= state_reg == IPC_ST_PAUSE
                ? prio_reg && !(irq_now || !pause_active || tif.expired)
                : go && instr_op == IPC_OP_PRIO_PAUSE && !quick
                  && |(pause_lines & instr_operand);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            done <= 1'b0;
            next_sel <= IPC_NEXT_P1;
        end else if (state_reg == IPC_ST_PAUSE) begin
            done <= irq_now || !pause_active || tif.expired;
            if (irq_now) begin
                next_sel <= IPC_NEXT_INTR;
            end else if (!pause_active) begin
                next_sel <= IPC_NEXT_P2;
            end else begin
                next_sel <= IPC_NEXT_P1;
            end
        end else if (go && is_pause) begin
            if (quick) begin
                done <= 1'b1;
                next_sel <= |(pause_lines[`IPC_PB_TYPE_REP:`IPC_PB_TYPE_BUSY]
                    & instr_operand[`IPC_PB_TYPE_REP:`IPC_PB_TYPE_BUSY])
                    ? IPC_NEXT_P1 : IPC_NEXT_P2;
            end else begin
                done <= !(|(pause_lines & instr_operand));
                next_sel <= IPC_NEXT_P2;
            end
        end else begin
            done <= go && instr_op != IPC_OP_NONE;
            next_sel <= (sns && !(|sense_hit)) ? IPC_NEXT_P2 : IPC_NEXT_P1;
        end
    end

    // ****************************************
    // accumulator, typewriter and peripheral pulses
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            acc_load <= 1'b0;
            acc_data <= 24'h000000;
        end else begin
            acc_load <= go && instr_op == IPC_OP_COPY_STATUS;
            if (go && instr_op == IPC_OP_COPY_STATUS) begin
                acc_data <= {interrupt_enable_mask_reg, status};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            type_finish_clr <= 1'b0;
            type_repeat_clr <= 1'b0;
            periph_int_clear <= 1'b0;
        end else begin
            type_finish_clr <= go && is_pause && instr_operand[`IPC_PB_TYPE_FIN]
                && !pause_lines[`IPC_PB_TYPE_FIN];
            type_repeat_clr <= go && is_pause && instr_operand[`IPC_PB_TYPE_REP]
                && !pause_lines[`IPC_PB_TYPE_REP];
            periph_int_clear <= go && instr_op == IPC_OP_CLEAR_FAULTS;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_COPY_LAYOUT: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        go && instr_op == IPC_OP_COPY_STATUS |=> acc_load && done && next_sel == IPC_NEXT_P1
        && acc_data[23:12] == $past(interrupt_enable_mask_reg))
        else $error("copy status result wrong");
    AST_PAUSE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        state_reg == IPC_ST_PAUSE && pause_active && !irq_now && !tif.expired
        |=> pc_hold && !done)
        else $error("pause did not hold counter");
    AST_PAUSE_TIMEOUT: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        state_reg == IPC_ST_PAUSE && tif.expired && pause_active && !irq_now
        |=> done && next_sel == IPC_NEXT_P1 && state_reg == IPC_ST_IDLE)
        else $error("pause timeout not to P+1");
    AST_PAUSE_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        state_reg == IPC_ST_PAUSE && !pause_active && !irq_now
        |=> done && next_sel == IPC_NEXT_P2 && !pc_hold)
        else $error("released pause not to P+2");
    AST_PAUSE_INTR: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        state_reg == IPC_ST_PAUSE && irq_now |=> done && next_sel == IPC_NEXT_INTR)
        else $error("interrupt did not end pause");
    AST_QUICK_NO_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        go && is_pause && quick |=> done && state_reg == IPC_ST_IDLE && !pc_hold)
        else $error("typewriter pause bits waited");
    AST_TYPE_FIN_CLR: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        go && is_pause && instr_operand[`IPC_PB_TYPE_FIN] && type_finish |=> type_finish_clr)
        else $error("finish flag not cleared");
    AST_PRIO_RTC: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        state_reg == IPC_ST_PAUSE && prio_reg && $past(state_reg) == IPC_ST_PAUSE
        |-> $past(rtc_inhibit))
        else $error("clock not stopped in priority pause");
    AST_SET_MASK: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        go && instr_op == IPC_OP_SET_MASK |=> interrupt_enable_mask_reg
        == ($past(interrupt_enable_mask_reg) | ($past(instr_operand) & {4'hF, CHAN_FITTED})))
        else $error("set mask wrong");
    AST_CLR_MASK: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        go && instr_op == IPC_OP_CLEAR_MASK |=> interrupt_enable_mask_reg
        == ($past(interrupt_enable_mask_reg) & ~$past(instr_operand)))
        else $error("clear mask wrong");
    AST_OFF_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
        !int_enabled |=> !int_request)
        else $error("request while disabled");
endmodule

/* tb.sv */
// self-checking bench for the interrupt and pause control block
`timescale 1ns/10ps
module tb;
    import ipc_pkg::*;
    logic sys_clk, rst_b, instr_valid, address_read_cycle, next_instruction_fetch, start;
    ipc_op_t instr_op;
    logic [11:0] instr_operand, int_mask;
    logic [2:0] instr_ch;
    logic [7:0] chan_ext_ctrl, chan_reply_reject, chan_parity_err, chan_busy_read;
    logic [7:0] chan_busy_write, chan_ext_reject, chan_noresp_reject, chan_preset;
    logic [7:0] chan_int_event, ext_int, chan_cleared, negate_lockout, lockout;
    logic [7:0] chan_xfer_busy, chan_op_done, span;
    logic illegal_write, type_busy, type_finish, type_repeat, search_move_busy;
    logic search_move_done, rtc_tick, exp_fault_event, ovf_fault_event, div_fault_event;
    logic bcd_fault_event, done, pc_hold, acc_load, int_request, int_enabled, rtc_inhibit;
    logic type_finish_clr, type_repeat_clr, periph_int_clear;
    logic [23:0] acc_data;
    logic [3:0] seen;
    ipc_next_t next_sel;
    int error_cnt = 0;
    int samples_checked = 0;
    // only channels 0-3 fitted, so mask bits 4-7 must refuse to set
    ipc_top #(.PAUSE_CYCLES(20), .CHAN_FITTED(8'h0F)) ipc_top_i (.*);
    ipc_chan_model ipc_chan_model_i (.sys_clk(sys_clk), .start(start), .span(span),
        .xfer_busy(chan_xfer_busy), .op_done(chan_op_done));
    always #12.5 sys_clk = ~sys_clk;
    task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", name, exp, got);
        end
    endtask
    // issue one instruction, gather the side pulses until done, check the exit
    task automatic run_op(input ipc_op_t op, input logic [11:0] opnd, input ipc_next_t nx);
        int n;
        n = 0;
        seen = 4'h0;
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_operand <= opnd;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        do begin
            @(negedge sys_clk);
            seen |= {periph_int_clear, type_finish_clr, rtc_inhibit, pc_hold};
            n++;
        end while (done !== 1'b1 && n < 100);
        check("done", done, 1'b1);
        check("next_sel", next_sel, nx);
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        give_verdict;
    end
    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        instr_op = IPC_OP_NONE;
        {instr_valid, address_read_cycle, next_instruction_fetch, start, instr_operand} = '0;
        {instr_ch, chan_ext_ctrl, chan_reply_reject, chan_parity_err, chan_busy_read} = '0;
        {chan_busy_write, chan_ext_reject, chan_noresp_reject, chan_preset, span} = '0;
        {chan_int_event, ext_int, chan_cleared, negate_lockout, illegal_write} = '0;
        {type_busy, type_finish, type_repeat, search_move_busy, search_move_done} = '0;
        {rtc_tick, exp_fault_event, ovf_fault_event, div_fault_event, bcd_fault_event} = '0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check("mask_rst", int_mask, 12'h000);
        run_op(IPC_OP_SET_MASK, 12'hFFF, IPC_NEXT_P1);
        check("mask_set", int_mask, 12'hF0F);
        illegal_write <= 1'b1;
        run_op(IPC_OP_COPY_STATUS, 12'h000, IPC_NEXT_P1);
        check("acc", acc_data, 24'hF0F020);
        check("acc_load", acc_load, 1'b1);
        run_op(IPC_OP_CLEAR_MASK, 12'h00F, IPC_NEXT_P1);
        check("mask_clr", int_mask, 12'hF00);
        run_op(IPC_OP_LOCKOUT, 12'h001, IPC_NEXT_P1);
        check("lockout", lockout, 8'h01);
        // one start beat only, a held start would keep the channel busy into a timeout
        start <= 1'b1;
        span <= 8'h06;
        @(posedge sys_clk);
        start <= 1'b0;
        run_op(IPC_OP_PAUSE, 12'h001, IPC_NEXT_P2);
        check("lock_rel", lockout, 8'h00);
        check("hold", seen[0], 1'b1);
        chan_ext_ctrl <= 8'h02;
        for (int i = 0; i < 2; i++) begin
            run_op(i ? IPC_OP_PRIO_PAUSE : IPC_OP_PAUSE, 12'h002, IPC_NEXT_P1);
            check("rtc_inh", seen[1], i);
        end
        chan_ext_ctrl <= 8'h00;
        type_finish <= 1'b1;
        run_op(IPC_OP_PAUSE, 12'h200, IPC_NEXT_P2);
        check("fin_clr", seen[2:0], 3'h4);
        type_busy <= 1'b1;
        run_op(IPC_OP_PAUSE, 12'h100, IPC_NEXT_P1);
        check("no_wait", seen[0], 1'b0);
        type_repeat <= 1'b1;
        run_op(IPC_OP_PAUSE, 12'h400, IPC_NEXT_P2);
        check("rep_clr", type_repeat_clr, 1'b1);
        for (int i = 0; i < 2; i++) begin
            run_op(i ? IPC_OP_DEC_FAULT : IPC_OP_FLOAT_FAULT, 12'h000, IPC_NEXT_P1);
            run_op(IPC_OP_SENSE_STATUS, 12'hF00, IPC_NEXT_P1);
            run_op(IPC_OP_SENSE_STATUS, 12'hF00, IPC_NEXT_P2);
        end
        run_op(IPC_OP_INT_ON, 12'h000, IPC_NEXT_P1);
        exp_fault_event <= 1'b1;
        @(posedge sys_clk);
        exp_fault_event <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            repeat (2) @(posedge sys_clk);
            check("irq_defer", int_request, 1'b0);
            next_instruction_fetch <= 1'b1;
            @(posedge sys_clk);
            next_instruction_fetch <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
        check("irq", int_request, 1'b1);
        start <= 1'b1;
        span <= 8'h1E;
        run_op(IPC_OP_PAUSE, 12'h001, IPC_NEXT_INTR);
        start <= 1'b0;
        run_op(IPC_OP_INT_OFF, 12'h000, IPC_NEXT_P1);
        @(negedge sys_clk);
        check("irq_off", {int_enabled, int_request}, 2'h0);
        run_op(IPC_OP_SENSE_STATUS, 12'h100, IPC_NEXT_P1);
        exp_fault_event <= 1'b1;
        @(posedge sys_clk);
        exp_fault_event <= 1'b0;
        run_op(IPC_OP_CLEAR_FAULTS, 12'h200, IPC_NEXT_P1);
        check("pclr", seen[3], 1'b1);
        run_op(IPC_OP_SENSE_STATUS, 12'h100, IPC_NEXT_P2);
        // long instruction after enable: only its second address read opens the gate
        run_op(IPC_OP_FLOAT_FAULT, 12'h000, IPC_NEXT_P1);
        run_op(IPC_OP_INT_ON, 12'h000, IPC_NEXT_P1);
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            next_instruction_fetch <= i == 0;
            address_read_cycle <= i != 0;
            @(posedge sys_clk);
            {next_instruction_fetch, address_read_cycle} <= 2'h0;
            repeat (2) @(negedge sys_clk);
            check("irq_address_read_cycle", int_request, i == 2);
        end
        give_verdict;
    end
endmodule
